//--- can_ps_pkg.sv
// Constants and types for the CAN power-save and interrupt block.
package can_ps_pkg;

    // Register byte offsets on the Avalon-MM slave.
    localparam logic [4:0] MODULE_CONTROL_OFS = 5'h00;
    localparam logic [4:0] INT_STATUS_OFS = 5'h04;
    localparam logic [4:0] INT_ENABLE_OFS = 5'h08;
    localparam logic [4:0] GLOBAL_CONTROL_OFS = 5'h0C;
    localparam logic [4:0] BUF_IRQ_ENABLE_OFS = 5'h10;
    localparam logic [4:0] LAST_RX_POINTER_OFS = 5'h14;
    localparam logic [4:0] LAST_TX_POINTER_OFS = 5'h18;

    // Field positions in the module control register.
    localparam int PS_LSB = 0;
    localparam int OPM_LSB = 4;

    // Power-save field codes.
    localparam logic [1:0] PS_NONE = 2'h0;
    localparam logic [1:0] PS_SLEEP_CODE = 2'h1;
    localparam logic [1:0] PS_STOP_CODE = 2'h3;

    // Operating mode codes; initialization is the reset mode.
    localparam logic [2:0] OPM_INIT = 3'h0;
    localparam logic [2:0] OPM_RX_ONLY = 3'h3;

    // Interrupt source bit positions.
    localparam int SRC_TX = 0;
    localparam int SRC_RX = 1;
    localparam int SRC_ERR_STATE = 2;
    localparam int SRC_PROTO = 3;
    localparam int SRC_ARB = 4;
    localparam int SRC_WAKE = 5;
    localparam int NUM_SRC = 6;

    // Recessive bits needed before rejoining bus traffic.
    localparam logic [3:0] REJOIN_BITS = 4'hB;

    localparam logic [5:0] INT_ENABLE_RST = 6'h00;

    typedef enum logic [2:0] {
        ST_RUN, ST_SLEEP_PEND, ST_SLEEP, ST_WOKEN, ST_STOP
    } ps_state_t;

endpackage

//--- can_power_save_and_irq.sv
// Power-save mode control and interrupt mapping of the CAN controller.
`timescale 1ns/10ps
module can_power_save_and_irq
    import can_ps_pkg::*;
#(
    parameter int NUM_BUF = 16,
    parameter int BUF_W = 4
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic can_receive_pin_in,
    input wire logic bit_tick_in,
    input wire logic bus_idle_in,
    input wire logic tx_pending_in,
    input wire logic mclk_gated_in,
    input wire logic tx_done_in,
    input wire logic [BUF_W-1:0] tx_buf_in,
    input wire logic rx_valid_in,
    input wire logic [BUF_W-1:0] rx_buf_in,
    input wire logic err_warning_in,
    input wire logic err_passive_in,
    input wire logic bus_off_in,
    input wire logic [4:0] proto_err_in,
    input wire logic arb_loss_in,
    output logic tx_irq_out,
    output logic rx_irq_out,
    output logic error_irq_out,
    output logic wakeup_irq_out,
    output logic wake_request_async_out,
    output logic tx_enable_out,
    output logic rx_enable_out,
    output logic buffer_access_ready_out,
    output logic [2:0] op_mode_out
);

    logic rst_meta_q, rst_n;
    ps_state_t state_q, state_d;
    logic [2:0] op_mode_q, op_mode_d;
    logic [NUM_SRC-1:0] int_status_q, int_status_d, int_set;
    logic [NUM_SRC-1:0] int_enable_q, int_enable_d;
    logic [NUM_BUF-1:0] buf_irq_en_q, buf_irq_en_d;
    logic [BUF_W-1:0] last_rx_q, last_rx_d, last_tx_q, last_tx_d;
    logic waitreq_q, acc, wr_acc;
    logic [31:0] rdata_d;
    logic wake_clr_n_q, wake_lat_q, wake_s1_q, wake_s2_q, wake_s3_q;
    logic gated_seen_q, gated_seen_d;
    logic [3:0] recess_cnt_q, recess_cnt_d;
    logic joined_q, joined_d;
    logic err_level_q;
    logic [3:0] irq_d;

    // Reset is released through two flops; everything else except the edge latch uses rst_n.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // Bus handshake: one wait cycle, then the access completes.
    wire req = avs_read_in | avs_write_in;
    // Read data are caught once per access so they stand until the next one.
    wire req_first = req & waitreq_q;
    assign acc = req & ~waitreq_q;
    assign wr_acc = acc & avs_write_in;

    // Address and field decode.
    wire [1:0] wr_ps = avs_writedata_in[PS_LSB +: 2];
    wire [2:0] wr_opm = avs_writedata_in[OPM_LSB +: 3];
    wire sel_ctrl = avs_address_in == MODULE_CONTROL_OFS;
    wire ctrl_wr = wr_acc & sel_ctrl;
    wire standby = (state_q == ST_SLEEP) || (state_q == ST_WOKEN) ||
                   (state_q == ST_STOP);
    wire awake = (state_q == ST_RUN) || (state_q == ST_SLEEP_PEND);
    wire init_req = ctrl_wr & awake & (wr_opm == OPM_INIT);
    wire sleep_req = ctrl_wr & (wr_ps == PS_SLEEP_CODE);
    wire cfg_wr = wr_acc & awake;

    // Wakeup edge seen in the clock domain after synchronising.
    wire wake_edge = wake_s2_q & ~wake_s3_q;

    // Field value as software reads it.
    wire [1:0] ps_field = (state_q == ST_STOP) ? PS_STOP_CODE :
                          (state_q == ST_SLEEP || state_q == ST_WOKEN) ?
                          PS_SLEEP_CODE : PS_NONE;

    // Power-save mode sequencing.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                // Sleep is refused from init; a same-write init wins.
                if (sleep_req && op_mode_q != OPM_INIT &&
                    wr_opm != OPM_INIT) begin
                    state_d = ST_SLEEP_PEND;
                end
            end
            ST_SLEEP_PEND: begin
                if (init_req) begin
                    state_d = ST_RUN;
                end else if (bus_idle_in && !tx_pending_in) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_edge && gated_seen_q) begin
                    state_d = ST_RUN;
                end else if (wake_edge) begin
                    state_d = ST_WOKEN;
                end else if (ctrl_wr && wr_ps == PS_NONE) begin
                    state_d = ST_RUN;
                end else if (ctrl_wr && wr_ps == PS_STOP_CODE) begin
                    state_d = ST_STOP;
                end
            end
            ST_WOKEN: begin
                if (ctrl_wr && !wr_ps[0]) begin
                    state_d = ST_RUN;
                end
            end
            ST_STOP: begin
                // Bus edges are ignored; other writes are dropped.
                if (ctrl_wr && wr_ps == PS_SLEEP_CODE) begin
                    state_d = ST_SLEEP;
                end
            end
            default: state_d = ST_RUN;
        endcase
    end

    // Operating mode survives standby untouched, so release returns to it.
    assign op_mode_d = (ctrl_wr && awake) ? wr_opm : op_mode_q;

    // Remember whether the clock was about to be stopped during sleep.
    assign gated_seen_d = (state_q == ST_SLEEP) &
                          (gated_seen_q | mclk_gated_in);

    // Interrupt source events.
    assign int_set[SRC_TX] = tx_done_in & buf_irq_en_q[tx_buf_in];
    assign int_set[SRC_RX] = rx_valid_in & buf_irq_en_q[rx_buf_in];
    wire err_level = err_warning_in | err_passive_in | bus_off_in;
    assign int_set[SRC_ERR_STATE] = err_level & ~err_level_q;
    assign int_set[SRC_PROTO] = |proto_err_in;
    assign int_set[SRC_ARB] = arb_loss_in;
    assign int_set[SRC_WAKE] = wake_edge & (state_q == ST_SLEEP);

    // Software writes 0 to clear a bit; a set in the same cycle wins.
    wire st_wr = cfg_wr & (avs_address_in == INT_STATUS_OFS);
    assign int_status_d = int_set | (int_status_q &
        (st_wr ? avs_writedata_in[NUM_SRC-1:0] : {NUM_SRC{1'b1}}));

    assign int_enable_d = (cfg_wr && avs_address_in == INT_ENABLE_OFS) ?
                          avs_writedata_in[NUM_SRC-1:0] : int_enable_q;
    assign buf_irq_en_d = (cfg_wr && avs_address_in == BUF_IRQ_ENABLE_OFS) ?
                          avs_writedata_in[NUM_BUF-1:0] : buf_irq_en_q;
    assign last_rx_d = rx_valid_in ? rx_buf_in : last_rx_q;
    assign last_tx_d = tx_done_in ? tx_buf_in : last_tx_q;

    // Request lines pulse when a source sets while enabled.
    wire [NUM_SRC-1:0] fire = int_set & int_enable_q;
    assign irq_d = {fire[SRC_WAKE],
                    fire[SRC_ERR_STATE] | fire[SRC_PROTO] | fire[SRC_ARB],
                    fire[SRC_RX], fire[SRC_TX]};

    // Rejoin after a run of recessive bits; any dominant bit restarts it.
    always_comb begin
        recess_cnt_d = recess_cnt_q;
        joined_d = joined_q;
        if (!awake) begin
            recess_cnt_d = 4'h0;
            joined_d = 1'b0;
        end else if (bit_tick_in && !joined_q) begin
            if (!can_receive_pin_in) begin
                recess_cnt_d = 4'h0;
            end else if (recess_cnt_q == REJOIN_BITS - 4'h1) begin
                joined_d = 1'b1;
            end else begin
                recess_cnt_d = recess_cnt_q + 4'h1;
            end
        end
    end

    // Read data; pointer registers read zero in standby.
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (sel_ctrl) begin
            rdata_d[PS_LSB +: 2] = ps_field;
            rdata_d[OPM_LSB +: 3] = op_mode_q;
        end else if (avs_address_in == INT_STATUS_OFS) begin
            rdata_d[NUM_SRC-1:0] = int_status_q;
        end else if (avs_address_in == INT_ENABLE_OFS) begin
            rdata_d[NUM_SRC-1:0] = int_enable_q;
        end else if (avs_address_in == GLOBAL_CONTROL_OFS) begin
            rdata_d[0] = buffer_access_ready_out;
        end else if (avs_address_in == BUF_IRQ_ENABLE_OFS) begin
            rdata_d[NUM_BUF-1:0] = buf_irq_en_q;
        end else if (avs_address_in == LAST_RX_POINTER_OFS) begin
            rdata_d[BUF_W-1:0] = standby ? '0 : last_rx_q;
        end else if (avs_address_in == LAST_TX_POINTER_OFS) begin
            rdata_d[BUF_W-1:0] = standby ? '0 : last_tx_q;
        end
    end

    // Edge latch runs without the module clock; cleared unless asleep.
    always_ff @(negedge can_receive_pin_in or negedge wake_clr_n_q) begin
        if (!wake_clr_n_q) begin
            wake_lat_q <= 1'b0;
        end else begin
            wake_lat_q <= 1'b1;
        end
    end

    // The request comes straight from the edge latch, so it rises even
    // while the module clock is stopped; it drops once sleep is left.
    assign wake_request_async_out = wake_lat_q;

    // Synchroniser for the latched edge; stage one feeds stage two only.
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            wake_s1_q <= 1'b0;
            wake_s2_q <= 1'b0;
            wake_s3_q <= 1'b0;
        end else begin
            wake_s1_q <= wake_lat_q;
            wake_s2_q <= wake_s1_q;
            wake_s3_q <= wake_s2_q;
        end
    end

    // Control and status registers.
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_RUN;
            op_mode_q <= OPM_INIT;
            int_status_q <= '0;
            int_enable_q <= INT_ENABLE_RST;
            buf_irq_en_q <= '0;
            last_rx_q <= '0;
            last_tx_q <= '0;
            gated_seen_q <= 1'b0;
            err_level_q <= 1'b0;
            recess_cnt_q <= 4'h0;
            joined_q <= 1'b0;
            wake_clr_n_q <= 1'b0;
        end else begin
            state_q <= state_d;
            op_mode_q <= op_mode_d;
            int_status_q <= int_status_d;
            int_enable_q <= int_enable_d;
            buf_irq_en_q <= buf_irq_en_d;
            last_rx_q <= last_rx_d;
            last_tx_q <= last_tx_d;
            gated_seen_q <= gated_seen_d;
            err_level_q <= err_level;
            recess_cnt_q <= recess_cnt_d;
            joined_q <= joined_d;
            wake_clr_n_q <= (state_d == ST_SLEEP);
        end
    end

    // Outputs, all registered.
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata_out <= 32'h0000_0000;
            waitreq_q <= 1'b1;
            avs_waitrequest_out <= 1'b1;
            {wakeup_irq_out, error_irq_out, rx_irq_out, tx_irq_out} <= 4'h0;
            tx_enable_out <= 1'b0;
            rx_enable_out <= 1'b0;
            buffer_access_ready_out <= 1'b0;
            op_mode_out <= OPM_INIT;
        end else begin
            avs_readdata_out <= req_first ? rdata_d : avs_readdata_out;
            waitreq_q <= ~(req & waitreq_q);
            avs_waitrequest_out <= ~(req & waitreq_q);
            {wakeup_irq_out, error_irq_out, rx_irq_out, tx_irq_out} <= irq_d;
            tx_enable_out <= awake & joined_d & (op_mode_d != OPM_INIT) &
                             (op_mode_d != OPM_RX_ONLY);
            rx_enable_out <= joined_d & (op_mode_d != OPM_INIT);
            buffer_access_ready_out <= awake & joined_d;
            op_mode_out <= op_mode_d;
        end
    end

endmodule // can_power_save_and_irq

//--- can_ps_props.sv
// Port checker for the CAN power-save and interrupt block.
`timescale 1ns/10ps
module can_ps_props (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic can_receive_pin_in,
    input wire logic bit_tick_in,
    input wire logic tx_done_in,
    input wire logic rx_valid_in,
    input wire logic err_warning_in,
    input wire logic err_passive_in,
    input wire logic bus_off_in,
    input wire logic [4:0] proto_err_in,
    input wire logic arb_loss_in,
    input wire logic tx_irq_out,
    input wire logic rx_irq_out,
    input wire logic error_irq_out,
    input wire logic wakeup_irq_out,
    input wire logic wake_request_async_out,
    input wire logic buffer_access_ready_out
);
    logic [3:0] rec_q;
    logic [3:0] rec_d;
    // Counts recessive bits in a row, saturating so it never wraps.
    assign rec_d = !can_receive_pin_in ? 4'h0 : rec_q + {3'h0, rec_q != 4'hF};
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) rec_q <= 4'h0;
        else if (bit_tick_in) rec_q <= rec_d;
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    wait_once_a: assert property ($fell(avs_waitrequest_out) |=>
        avs_waitrequest_out) else $error("waitrequest low too long");
    wait_answer_a: assert property ((avs_read_in || avs_write_in) &&
        avs_waitrequest_out |-> ##[1:2] !avs_waitrequest_out)
        else $error("bus request not answered");
    hold_rdata_a: assert property (avs_waitrequest_out &&
        $past(avs_waitrequest_out) |-> $stable(avs_readdata_out))
        else $error("read data changed while idle");
    tx_cause_a: assert property (tx_irq_out |-> $past(tx_done_in))
        else $error("transmit request without event");
    rx_cause_a: assert property (rx_irq_out |-> $past(rx_valid_in))
        else $error("receive request without event");
    err_cause_a: assert property (error_irq_out |-> $past(arb_loss_in ||
        (|proto_err_in) || err_warning_in || err_passive_in || bus_off_in))
        else $error("error request without event");
    wake_pulse_a: assert property (wakeup_irq_out |=> !wakeup_irq_out)
        else $error("wakeup request longer than a pulse");
    wake_standby_a: assert property ($rose(wake_request_async_out) |->
        !buffer_access_ready_out) else $error("buffers open in sleep");
    rejoin_a: assert property ($rose(buffer_access_ready_out) |->
        rec_q >= 4'hB) else $error("rejoined before eleven recessive bits");
    cover property (wakeup_irq_out);
    cover property (error_irq_out);
    cover property ($rose(buffer_access_ready_out));
endmodule // can_ps_props

bind can_power_save_and_irq can_ps_props can_ps_props_i (.mclk_in,
    .rst_n_in, .avs_read_in, .avs_write_in, .avs_readdata_out,
    .avs_waitrequest_out, .can_receive_pin_in, .bit_tick_in, .tx_done_in,
    .rx_valid_in, .err_warning_in, .err_passive_in, .bus_off_in,
    .proto_err_in, .arb_loss_in, .tx_irq_out, .rx_irq_out, .error_irq_out,
    .wakeup_irq_out, .wake_request_async_out, .buffer_access_ready_out);

//--- can_bus_node.sv
// Behavioural model of the other nodes on the CAN bus.
`timescale 1ns/10ps
module can_bus_node (
    input wire logic mclk_in,
    output logic rx_pin_out,
    output logic bit_tick_out,
    output logic bus_idle_out
);
    logic [1:0] div_q = 2'h0;
    logic rx_q = 1'b1;
    // Bit ticks come every fourth clock and stop when the clock stops.
    always @(posedge mclk_in) begin
        div_q <= div_q + 2'h1;
    end
    assign bit_tick_out = (div_q == 2'h3);
    assign rx_pin_out = rx_q;
    assign bus_idle_out = rx_q; // A recessive line means no frame is on.
    // A dominant start edge; timed by delay so it works with no clock.
    task automatic wake_edge(input int bits);
        #1 rx_q = 1'b0;
        repeat (bits * 4) #5;
        rx_q = 1'b1;
    endtask
endmodule // can_bus_node

//--- tb.sv
// Self-checking bench for the CAN power-save and interrupt block.
`timescale 1ns/10ps
module tb;
    import can_ps_pkg::*;
    localparam logic [31:0] NORM = 32'h10;
    logic mclk_in = 1'b0, rst_n_in = 1'b0, run = 1'b1, avs_read_in = 1'b0;
    logic avs_write_in = 1'b0, tx_pending_in = 1'b0, mclk_gated_in = 1'b0;
    logic tx_done_in = 1'b0, rx_valid_in = 1'b0, arb_loss_in = 1'b0;
    logic [4:0] avs_address_in = '0, proto_err_in = '0;
    logic [31:0] avs_writedata_in = '0, avs_readdata_out, bm;
    logic [3:0] tx_buf_in = '0, rx_buf_in = '0, b;
    logic [2:0] lvl = '0, op_mode_out;
    logic [5:0] en;
    logic avs_waitrequest_out, rxd, tick, idle, tx_irq_out, rx_irq_out;
    logic error_irq_out, wakeup_irq_out, wake_request_async_out;
    logic tx_enable_out, rx_enable_out, buffer_access_ready_out;
    int errors = 0, n_checks = 0, s, ln, cnt, irq_n[4] = '{default: 0};
    // The clock halts low while run is cleared.
    always #2.5 mclk_in = ~mclk_in & run;
    can_power_save_and_irq can_power_save_and_irq_i (.mclk_in, .rst_n_in,
        .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
        .avs_readdata_out, .avs_waitrequest_out, .can_receive_pin_in(rxd),
        .bit_tick_in(tick), .bus_idle_in(idle), .tx_pending_in,
        .mclk_gated_in, .tx_done_in, .tx_buf_in, .rx_valid_in, .rx_buf_in,
        .err_warning_in(lvl[0]), .err_passive_in(lvl[1]),
        .bus_off_in(lvl[2]), .proto_err_in, .arb_loss_in, .tx_irq_out,
        .rx_irq_out, .error_irq_out, .wakeup_irq_out,
        .wake_request_async_out, .tx_enable_out, .rx_enable_out,
        .buffer_access_ready_out, .op_mode_out);
    can_bus_node can_bus_node_i (.mclk_in, .rx_pin_out(rxd),
        .bit_tick_out(tick), .bus_idle_out(idle));
    // Counts request pulses per line, so timing slack cannot hide one.
    always @(posedge mclk_in) begin
        irq_n[0] += int'(tx_irq_out === 1'b1);
        irq_n[1] += int'(rx_irq_out === 1'b1);
        irq_n[2] += int'(error_irq_out === 1'b1);
        irq_n[3] += int'(wakeup_irq_out === 1'b1);
    end
    function automatic int line_of(input int src);
        return src < 2 ? src : (src == 5 ? 3 : 2);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Holds the request until waitrequest is sampled low, then releases.
    task automatic bus(input logic w, input logic [4:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        @(posedge mclk_in);
        avs_read_in <= !w;
        avs_write_in <= w;
        avs_address_in <= a;
        avs_writedata_in <= d;
        do begin
            @(posedge mclk_in);
            k++;
        end while (avs_waitrequest_out !== 1'b0 && k < 50);
        q = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        if (k == 50) errors++;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task automatic settle();
        for (int k = 0; k < 300 && buffer_access_ready_out !== 1'b1; k++)
            @(posedge mclk_in);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #300000;
        errors++;
        results();
    end
    initial begin
        void'($urandom(40876));
        repeat (4) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        repeat (30) @(posedge mclk_in);
        rd(MODULE_CONTROL_OFS, 32'h0);
        rd(INT_ENABLE_OFS, 32'h0);
        rd(5'h1C, 32'h0);
        bm = $urandom;
        wr(BUF_IRQ_ENABLE_OFS, {16'h0, bm[15:0]});
        wr(MODULE_CONTROL_OFS, NORM);
        settle();
        rd(GLOBAL_CONTROL_OFS, 32'h1);
        chk({tx_enable_out, rx_enable_out}, 2'h3);
        $display("test reset and setup finished");
        // Every source except wakeup with random masks and buffer numbers.
        for (int t = 0; t < 25; t++) begin
            s = t % 5;
            b = 4'($urandom);
            en = 6'($urandom);
            wr(INT_ENABLE_OFS, {26'h0, en});
            ln = line_of(s);
            cnt = irq_n[ln];
            @(posedge mclk_in);
            tx_buf_in <= b;
            rx_buf_in <= b;
            tx_done_in <= (s == 0);
            rx_valid_in <= (s == 1);
            lvl <= (s == 2) ? 3'h1 << (t / 5 % 3) : 3'h0;
            proto_err_in <= (s == 3) ? 5'h1 << (t / 5) : 5'h0;
            arb_loss_in <= (s == 4);
            @(posedge mclk_in);
            {tx_done_in, rx_valid_in, arb_loss_in, lvl} <= 6'h0;
            proto_err_in <= 5'h0;
            repeat (4) @(posedge mclk_in);
            chk(irq_n[ln] - cnt, en[s] & (s > 1 | bm[b]));
            if (s > 1) begin
                rd(INT_STATUS_OFS, 32'h1 << s);
                wr(INT_STATUS_OFS, 32'h3F ^ (32'h1 << s));
                rd(INT_STATUS_OFS, 32'h0);
            end else
                wr(INT_STATUS_OFS, 32'h0);
        end
        $display("test interrupt sources finished");
        wr(MODULE_CONTROL_OFS, NORM | 32'h3);
        rd(MODULE_CONTROL_OFS, NORM);
        wr(INT_ENABLE_OFS, 32'h1F);
        tx_pending_in <= 1'b1;
        wr(MODULE_CONTROL_OFS, NORM | 32'h1);
        rd(MODULE_CONTROL_OFS, NORM);
        tx_pending_in <= 1'b0;
        repeat (10) @(posedge mclk_in);
        rd(MODULE_CONTROL_OFS, NORM | 32'h1);
        chk(buffer_access_ready_out, 1'b0);
        wr(INT_ENABLE_OFS, 32'h3F);
        rd(INT_ENABLE_OFS, 32'h1F);
        rd(LAST_RX_POINTER_OFS, 32'h0);
        wr(MODULE_CONTROL_OFS, 32'h1);
        chk(op_mode_out, 3'h1);
        wr(MODULE_CONTROL_OFS, NORM | 32'h3);
        rd(MODULE_CONTROL_OFS, NORM | 32'h3);
        tx_pending_in <= 1'b1;
        can_bus_node_i.wake_edge(2);
        repeat (10) @(posedge mclk_in);
        chk(tx_enable_out, 1'b0);
        rd(MODULE_CONTROL_OFS, NORM | 32'h3);
        wr(MODULE_CONTROL_OFS, 32'h30);
        rd(MODULE_CONTROL_OFS, NORM | 32'h3);
        wr(MODULE_CONTROL_OFS, NORM | 32'h1);
        rd(MODULE_CONTROL_OFS, NORM | 32'h1);
        tx_pending_in <= 1'b0;
        cnt = irq_n[3];
        can_bus_node_i.wake_edge(2);
        repeat (10) @(posedge mclk_in);
        chk(rx_enable_out, 1'b0);
        rd(INT_STATUS_OFS, 32'h20);
        chk(irq_n[3] - cnt, 32'h0);
        rd(MODULE_CONTROL_OFS, NORM | 32'h1);
        wr(MODULE_CONTROL_OFS, NORM);
        rd(MODULE_CONTROL_OFS, NORM);
        settle();
        chk(buffer_access_ready_out, 1'b1);
        wr(INT_STATUS_OFS, 32'h0);
        wr(MODULE_CONTROL_OFS, NORM | 32'h1);
        repeat (10) @(posedge mclk_in);
        wr(MODULE_CONTROL_OFS, NORM);
        rd(MODULE_CONTROL_OFS, NORM);
        settle();
        $display("test sleep and stop finished");
        wr(INT_ENABLE_OFS, 32'h20);
        mclk_gated_in <= 1'b1;
        wr(MODULE_CONTROL_OFS, NORM | 32'h1);
        repeat (10) @(posedge mclk_in);
        rd(MODULE_CONTROL_OFS, NORM | 32'h1);
        cnt = irq_n[3];
        run = 1'b0;
        #50;
        can_bus_node_i.wake_edge(2);
        chk(wake_request_async_out, 1'b1);
        #50;
        run = 1'b1;
        repeat (10) @(posedge mclk_in);
        mclk_gated_in <= 1'b0;
        rd(MODULE_CONTROL_OFS, NORM);
        rd(INT_STATUS_OFS, 32'h20);
        chk(irq_n[3] - cnt, 32'h1);
        chk(wake_request_async_out, 1'b0);
        wr(MODULE_CONTROL_OFS, 32'h30);
        settle();
        chk({tx_enable_out, rx_enable_out}, 2'h1);
        chk(op_mode_out, 3'h3);
        $display("test clockless wakeup finished");
        results();
    end
endmodule // tb
